// ===== include/fac_pkg.sv
// Purpose: Shared constants and types for the function action controller
// Assumes: 200 MHz system clock, word-addressed register port
// Notes: Offsets are register indices on the plain register port
package fac_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS * CLK_MHZ / 1000;
	localparam int US_NS = 1000;
	localparam int US_CYCLES = US_NS * CLK_MHZ / 1000;
	localparam logic [7:0] DETECT_MS = 8'h32;
	localparam logic [9:0] SPEED_WIN_MS = 10'h3E8;
	localparam logic [1:0] DEBOUNCE_MS = 2'h2;
	localparam logic [5:0] KICK_UNIT_MS = 6'h32;
	localparam logic [7:0] KICK_MAX_UNITS = 8'hFA;
	localparam logic [14:0] SERVO_FRAME_US = 15'h4E20;
	localparam logic [14:0] SERVO_BASE_US = 15'h03E8;
	// ------------------------------------------------------------
	// Register indices
	// ------------------------------------------------------------
	localparam logic [5:0] REG_CTRL = 6'h00;
	localparam logic [5:0] REG_ADDR = 6'h01;
	localparam logic [5:0] REG_STATUS = 6'h02;
	localparam logic [5:0] REG_STATS = 6'h03;
	localparam logic [5:0] REG_SPEED = 6'h04;
	localparam logic [5:0] REG_DIST = 6'h05;
	localparam logic [5:0] REG_KICK = 6'h06;
	localparam logic [5:0] REG_OUT_BASE = 6'h08;
	localparam logic [5:0] REG_MAP_BASE = 6'h10;
	localparam logic [5:0] REG_SERVO_BASE = 6'h1A;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam logic [13:0] ADDR_RESET = 14'h0003;
	localparam int N_OUT = 5;
	localparam int N_ACT = 10;
	localparam int REAR_IDX = 1;
	// Speed step modes
	localparam logic [1:0] STEPS_14 = 2'h0;
	localparam logic [1:0] STEPS_28 = 2'h1;
	localparam logic [1:0] STEPS_128 = 2'h2;
	// Address ranges per format
	localparam logic [13:0] ALT_ADDR_MAX = 14'h00FF;
	localparam logic [13:0] DCC_SHORT_MAX = 14'h007F;
	localparam logic [13:0] DCC_LONG_MAX = 14'h27FF;

	typedef enum logic [2:0] {
		ST_DETECT = 3'h1,
		ST_DIGITAL = 3'h2,
		ST_ANALOG = 3'h4
	} mode_t;

	// Decoded packet from the track front end
	typedef struct packed {
		logic valid;
		logic fault;
		logic is_dcc;
		logic long_addr;
		logic [13:0] addr;
		logic dir_fwd;
		logic [1:0] step_mode;
		logic [6:0] speed;
		logic [28:0] fn;
	} pkt_t;

	// Register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [5:0] addr;
		logic [31:0] wdata;
	} bus_req_t;
endpackage : fac_pkg

// ===== design/function_action_controller.sv
// Purpose: Action logic of a vehicle function decoder
// Assumes: Packets arrive decoded on clk_sys_in; pins are asynchronous
// Notes: Feedback outputs are requests to a transmitter outside
//
// The register addresses and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
module function_action_controller
	import fac_pkg::*;
#(
	parameter int TICK_CYCLES = MS_CYCLES
) (
	input wire logic clk_sys_in, // System clock
	input wire logic sys_rst_in, // Synchronous reset, high
	input wire bus_req_t bus_in, // Register port request
	output logic [31:0] bus_rdata_out, // Read data, cycle after read
	input wire pkt_t pkt_in, // Decoded track packet
	input wire logic track_dc_in, // Pin: DC supply sensed
	input wire logic dc_dir_in, // Pin: DC polarity, high forward
	input wire logic wheel_in, // Pin: wheel sensor contact
	input wire logic [1:0] pin_in, // Pins: configurable, input side
	output logic [1:0] pin_out, // Pins: servo pulse drive
	output logic [1:0] pin_oe_n_out, // Pins: low while driving
	output logic [N_OUT-1:0] fn_out, // Function outputs
	output logic [2:0] sound_out, // Sound triggers, one-cycle pulse
	output logic fb_ch1_out, // Channel 1 address request pulse
	output logic fb_ch2_out, // Channel 2 reply request pulse
	output logic fb_dyn_out // Dynamic values waiting to be sent
);
	// ------------------------------------------------------------
	// Input synchronisers and time bases
	// ------------------------------------------------------------
	logic [4:0] sync1_reg, sync2_reg;
	logic [17:0] ms_cnt_reg;
	logic [7:0] us_cnt_reg;
	wire ms_tick = ms_cnt_reg == 18'(TICK_CYCLES - 1);
	wire us_tick = us_cnt_reg == 8'(US_CYCLES - 1);
	wire dc_seen = sync2_reg[0];
	wire dc_fwd = sync2_reg[1];

	// First stage feeds only the second
	always_ff @(posedge clk_sys_in) begin
		sync1_reg <= {pin_in, wheel_in, dc_dir_in, track_dc_in};
		sync2_reg <= sync1_reg;
	end

	// Millisecond and microsecond ticks
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			ms_cnt_reg <= '0;
			us_cnt_reg <= '0;
		end else begin
			ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + 18'h1;
			us_cnt_reg <= us_tick ? '0 : us_cnt_reg + 8'h1;
		end
	end

	// ------------------------------------------------------------
	// Debounce: wheel sensor and both pins, stable for whole ms
	// ------------------------------------------------------------
	logic [2:0] deb_reg, deb_evt;
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_deb
			logic [1:0] stable_reg;
			wire raw = sync2_reg[g+2];
			// A level held across ticks is taken; bounces restart it
			always_ff @(posedge clk_sys_in) begin
				if (sys_rst_in) begin
					stable_reg <= '0;
					deb_reg[g] <= 1'b0;
				end else if (raw == deb_reg[g]) begin
					stable_reg <= '0;
				end else if (ms_tick) begin
					stable_reg <= stable_reg + 2'h1;
					if (stable_reg == DEBOUNCE_MS - 2'h1)
						deb_reg[g] <= raw;
				end
			end
			assign deb_evt[g] = ms_tick && raw && !deb_reg[g] &&
				stable_reg == DEBOUNCE_MS - 2'h1;
		end
	endgenerate
	wire wheel_evt = deb_evt[0];

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic [31:0] ctrl_reg, kick_reg;
	logic [13:0] addr_reg;
	logic [31:0] out_cfg_reg [N_OUT];
	logic [18:0] map_reg [N_ACT];
	logic [15:0] servo_reg [2];
	logic [15:0] total_reg, faulty_reg, speed_reg;
	logic [31:0] dist_reg;
	mode_t mode_reg;
	logic fmt_dcc_reg, dir_reg;
	logic [6:0] speed_step_reg;
	logic [28:0] fn_reg;
	wire analog_en = ctrl_reg[0];
	wire pulse_ind = ctrl_reg[1];
	wire [1:0] is_servo = ctrl_reg[3:2];
	wire [1:0] magnets_m1 = ctrl_reg[5:4];
	wire [5:0] ra = bus_in.addr;
	wire stats_clr = bus_in.wr && ra == REG_STATS;
	wire [5:0] out_idx = ra - REG_OUT_BASE;
	wire [5:0] map_idx = ra - REG_MAP_BASE;
	wire is_out = ra >= REG_OUT_BASE && ra < REG_OUT_BASE + 6'(N_OUT);
	wire is_map = ra >= REG_MAP_BASE && ra < REG_MAP_BASE + 6'(N_ACT);
	wire is_srv = ra == REG_SERVO_BASE || ra == REG_SERVO_BASE + 6'h1;
	wire [31:0] status_w = {18'h0, deb_reg[2:1], speed_step_reg,
		dir_reg, fmt_dcc_reg, mode_reg};

	// Read mux; unmapped addresses read zero
	wire [31:0] rd_mux =
		ra == REG_CTRL ? ctrl_reg :
		ra == REG_ADDR ? {18'h0, addr_reg} :
		ra == REG_STATUS ? status_w :
		ra == REG_STATS ? {faulty_reg, total_reg} :
		ra == REG_SPEED ? {16'h0, speed_reg} :
		ra == REG_DIST ? dist_reg :
		ra == REG_KICK ? kick_reg :
		is_out ? out_cfg_reg[out_idx[2:0]] :
		is_map ? {13'h0, map_reg[map_idx[3:0]]} :
		is_srv ? {16'h0, servo_reg[ra[0]]} : 32'h0;

	// Writable configuration
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			ctrl_reg <= CTRL_RESET;
			addr_reg <= ADDR_RESET;
			kick_reg <= '0;
			bus_rdata_out <= '0;
			for (int i = 0; i < N_OUT; i++)
				out_cfg_reg[i] <= '0;
			for (int i = 0; i < N_ACT; i++)
				map_reg[i] <= '0;
			servo_reg[0] <= '0;
			servo_reg[1] <= '0;
		end else begin
			bus_rdata_out <= bus_in.rd ? rd_mux : '0;
			if (bus_in.wr) begin
				if (ra == REG_CTRL)
					ctrl_reg <= bus_in.wdata;
				if (ra == REG_ADDR)
					addr_reg <= bus_in.wdata[13:0];
				if (ra == REG_KICK)
					kick_reg <= bus_in.wdata;
				if (is_out)
					out_cfg_reg[out_idx[2:0]] <= bus_in.wdata;
				if (is_map)
					map_reg[map_idx[3:0]] <= bus_in.wdata[18:0];
				if (is_srv)
					servo_reg[ra[0]] <= bus_in.wdata[15:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Packet intake: format, address, speed, functions
	// ------------------------------------------------------------
	wire [13:0] pa = pkt_in.addr;
	wire addr_ok = pkt_in.is_dcc ?
		(pkt_in.long_addr ? pa <= DCC_LONG_MAX : pa <= DCC_SHORT_MAX) :
		pa <= ALT_ADDR_MAX;
	wire own = pkt_in.valid && !pkt_in.fault && addr_ok &&
		pa != 14'h0 && pa == addr_reg;
	wire [1:0] smode = pkt_in.is_dcc ? pkt_in.step_mode : STEPS_14;
	wire [6:0] sp = pkt_in.speed;
	// Scale 14 steps by 9 onto 0..126 and 28 steps by 4; 128 steps pass as is, for speed dimming
	wire [6:0] sp_norm =
		smode == STEPS_14 ? 7'({sp[3:0], 3'h0} + {3'h0, sp[3:0]}) :
		smode == STEPS_28 ? 7'({sp[4:0], 2'h0}) : sp;
	wire [28:0] fn_new = pkt_in.is_dcc ? pkt_in.fn :
		{24'h0, pkt_in.fn[4:0]};

	// Own packets update drive state; format is followed per packet
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			fmt_dcc_reg <= 1'b0;
			dir_reg <= 1'b1;
			speed_step_reg <= '0;
			fn_reg <= '0;
		end else if (own) begin
			fmt_dcc_reg <= pkt_in.is_dcc;
			dir_reg <= pkt_in.dir_fwd;
			speed_step_reg <= sp_norm;
			fn_reg <= fn_new;
		end else if (mode_reg == ST_ANALOG) begin
			dir_reg <= dc_fwd;
		end
	end

	// ------------------------------------------------------------
	// Mode detection after reset
	// ------------------------------------------------------------
	logic [7:0] det_cnt_reg;
	wire good_pkt = pkt_in.valid && !pkt_in.fault;
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			mode_reg <= ST_DETECT;
			det_cnt_reg <= '0;
		end else begin
			unique case (mode_reg)
				ST_DETECT: begin
					if (good_pkt)
						mode_reg <= ST_DIGITAL;
					else if (det_cnt_reg == DETECT_MS)
						mode_reg <= (dc_seen && analog_en) ?
							ST_ANALOG : ST_DIGITAL;
					if (ms_tick)
						det_cnt_reg <= det_cnt_reg + 8'h1;
				end
				ST_ANALOG: begin
					if (good_pkt || !analog_en)
						mode_reg <= ST_DIGITAL;
				end
				ST_DIGITAL: mode_reg <= ST_DIGITAL;
			endcase
		end
	end
	wire analog = mode_reg == ST_ANALOG;

	// ------------------------------------------------------------
	// Feedback requests and reception statistics
	// ------------------------------------------------------------
	logic speed_upd;
	wire dcc_pkt = good_pkt && pkt_in.is_dcc && !analog;
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			fb_ch1_out <= 1'b0;
			fb_ch2_out <= 1'b0;
			fb_dyn_out <= 1'b0;
			total_reg <= '0;
			faulty_reg <= '0;
		end else begin
			fb_ch1_out <= dcc_pkt;
			fb_ch2_out <= dcc_pkt && own;
			// New speed window wins over the send that clears it
			if (speed_upd)
				fb_dyn_out <= 1'b1;
			else if (dcc_pkt && own)
				fb_dyn_out <= 1'b0;
			if (stats_clr) begin
				total_reg <= '0;
				faulty_reg <= '0;
			end else if (pkt_in.valid) begin
				total_reg <= total_reg + 16'h1;
				if (pkt_in.fault)
					faulty_reg <= faulty_reg + 16'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Wheel pulses: revolutions, speed per window, distance
	// ------------------------------------------------------------
	logic [1:0] mag_cnt_reg;
	logic [9:0] win_cnt_reg;
	logic [15:0] rev_win_reg;
	wire rev = wheel_evt && mag_cnt_reg == magnets_m1;
	assign speed_upd = ms_tick && win_cnt_reg == SPEED_WIN_MS - 10'h1;
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			mag_cnt_reg <= '0;
			win_cnt_reg <= '0;
			rev_win_reg <= '0;
			speed_reg <= '0;
			dist_reg <= '0;
		end else begin
			if (wheel_evt)
				mag_cnt_reg <= rev ? 2'h0 : mag_cnt_reg + 2'h1;
			if (rev)
				dist_reg <= dist_reg + 32'h1;
			if (speed_upd) begin
				speed_reg <= rev_win_reg;
				rev_win_reg <= {15'h0, rev};
				win_cnt_reg <= '0;
			end else begin
				rev_win_reg <= rev_win_reg + {15'h0, rev};
				if (ms_tick)
					win_cnt_reg <= win_cnt_reg + 10'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Action mapping: 0..4 outputs, 5..6 servos, 7..9 sounds
	// ------------------------------------------------------------
	logic [N_ACT-1:0] act;
	generate
		for (g = 0; g < N_ACT; g++) begin : g_map
			wire [18:0] m = map_reg[g];
			wire [4:0] sel = dir_reg ? m[4:0] : m[9:5];
			wire fn_on = sel <= 5'h1C && fn_reg[sel] &&
				!(m[15] && fn_reg[m[14:10]]);
			// Servos ignore the contacts
			wire in_on = (g < N_OUT || g > 6) && m[17] &&
				deb_reg[m[18] + 1] && !is_servo[m[18]];
			assign act[g] = (m[16] && fn_on) || in_on;
		end
	endgenerate

	// Sounds fire once on the rising edge of their action
	logic [2:0] snd_prev_reg;
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			snd_prev_reg <= '0;
			sound_out <= '0;
		end else begin
			snd_prev_reg <= act[9:7];
			sound_out <= act[9:7] & ~snd_prev_reg;
		end
	end

	// ------------------------------------------------------------
	// Output effects: invert, kick, flash, dimming
	// ------------------------------------------------------------
	logic [7:0] pwm_reg;
	logic ind_reg;
	logic [13:0] kick_lim;
	assign kick_lim = 14'((kick_reg[7:0] > KICK_MAX_UNITS ? KICK_MAX_UNITS :
		kick_reg[7:0]) * KICK_UNIT_MS);
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			pwm_reg <= '0;
			ind_reg <= 1'b0;
		end else begin
			pwm_reg <= pwm_reg + 8'h1;
			if (wheel_evt && pulse_ind)
				ind_reg <= !ind_reg;
		end
	end
	generate
		for (g = 0; g < N_OUT; g++) begin : g_out
			wire [31:0] c = out_cfg_reg[g];
			logic [13:0] kick_cnt_reg;
			logic [7:0] fl_cnt_reg;
			logic base_prev_reg;
			// Only outputs with function switching enabled count as F0 ones
			wire f0_map = map_reg[g][16] &&
				(map_reg[g][4:0] == 5'h0 || map_reg[g][9:5] == 5'h0);
			wire dc_f0 = dir_reg ? map_reg[g][4:0] == 5'h0 :
				map_reg[g][9:5] == 5'h0;
			wire an_on = f0_map ? dc_f0 : c[5];
			wire base = (analog ? an_on : act[g]) ^ c[0];
			wire kicking = kick_cnt_reg != 14'h0;
			wire fl_on = !c[1] || fl_cnt_reg < c[31:24];
			wire [7:0] sdim = 8'(({1'b0, c[15:8]} +
				{1'b0, speed_step_reg, 1'b0}) > 9'hFF ? 8'hFF :
				c[15:8] + {speed_step_reg, 1'b0});
			wire [7:0] lvl = (g == REAR_IDX) ? 8'hFF :
				c[3] ? c[15:8] : c[4] ? sdim : 8'hFF;
			wire on = c[2] ? kicking : base && fl_on;
			wire drive = (g == REAR_IDX && pulse_ind) ? ind_reg :
				on && (kicking || lvl == 8'hFF || pwm_reg < lvl);
			always_ff @(posedge clk_sys_in) begin
				if (sys_rst_in) begin
					kick_cnt_reg <= '0;
					fl_cnt_reg <= '0;
					base_prev_reg <= 1'b0;
					fn_out[g] <= 1'b0;
				end else begin
					base_prev_reg <= base;
					fn_out[g] <= drive;
					if (base && !base_prev_reg && c[2])
						kick_cnt_reg <= kick_lim;
					else if (!base)
						kick_cnt_reg <= '0;
					else if (ms_tick && kicking)
						kick_cnt_reg <= kick_cnt_reg - 14'h1;
					if (ms_tick)
						fl_cnt_reg <= fl_cnt_reg >= c[23:16] ? 8'h0 :
							fl_cnt_reg + 8'h1;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Servo pulses on the configurable pins, 20 ms frame
	// ------------------------------------------------------------
	logic [14:0] frame_reg;
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			frame_reg <= '0;
			pin_out <= '0;
			pin_oe_n_out <= 2'h3;
		end else begin
			if (us_tick)
				frame_reg <= frame_reg == SERVO_FRAME_US - 15'h1 ? 15'h0 :
					frame_reg + 15'h1;
			for (int i = 0; i < 2; i++) begin
				pin_oe_n_out[i] <= !is_servo[i];
				pin_out[i] <= is_servo[i] && frame_reg < SERVO_BASE_US +
					{5'h0, act[5+i] ? servo_reg[i][7:0] :
					servo_reg[i][15:8], 2'h0};
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_dcc_in;
		good_pkt && pkt_in.is_dcc && !analog;
	endsequence
	AST_FB_CH1: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in) s_dcc_in |=> fb_ch1_out)
		else $error("channel 1 not requested after DCC packet");
	AST_FB_ALT: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in) fb_ch1_out |-> $past(pkt_in.is_dcc))
		else $error("feedback after alternate format packet");
	AST_CH2_OWN: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in) fb_ch2_out |-> $past(own) && fb_ch1_out)
		else $error("channel 2 without own address");
	AST_STATS: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in) pkt_in.valid && !stats_clr |=>
		total_reg == $past(total_reg) + 16'h1)
		else $error("total packet count not advanced");
	AST_SERVO_OE: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in) $stable(is_servo) ##1 $stable(is_servo)
		|-> pin_oe_n_out == ~is_servo)
		else $error("pin drive does not follow servo setting");
	AST_KICK_BOUND: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in) g_out[0].kick_cnt_reg <= 14'h30D4)
		else $error("kick time above limit");
	AST_ANALOG_MODE: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in) !analog_en |=> !analog)
		else $error("analogue mode while detection disabled");
	AST_PULSE_TOGGLE: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in) wheel_evt && pulse_ind |=>
		ind_reg != $past(ind_reg) ##1 fn_out[REAR_IDX] == $past(ind_reg))
		else $error("rear light did not toggle on wheel event");
endmodule : function_action_controller

// ===== verification/track_source.sv
// Purpose: Stand-in for the command station feeding decoded packets
// Assumes: Packets reach the decoder already framed on the system clock
// Notes: Fields turn to their inverse outside the valid cycle
`timescale 1ns/1ps
module track_source
	import fac_pkg::*;
(
	input wire logic clk_sys_in, // System clock
	output pkt_t pkt_out // Packet toward the decoder
);
	// ------------------------------------------------------------
	// Packet sender
	// ------------------------------------------------------------
	initial begin
		pkt_out = '0;
	end

	// One packet per call; a design that samples outside valid sees garbage
	task automatic send(input logic d, l, input logic [13:0] a,
		input logic fw, input logic [28:0] f, input logic ft);
		pkt_t p;
		p = '0;
		p.valid = 1'b1;
		p.fault = ft;
		p.is_dcc = d;
		p.long_addr = l;
		p.addr = a;
		p.dir_fwd = fw;
		p.step_mode = d ? STEPS_28 : STEPS_14;
		p.speed = 7'h05;
		p.fn = d ? f : {24'h0, f[4:0]};
		@(posedge clk_sys_in);
		pkt_out <= p;
		@(posedge clk_sys_in);
		p = ~p;
		p.valid = 1'b0;
		pkt_out <= p;
	endtask : send
endmodule : track_source

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the function action controller
// Assumes: Millisecond tick shortened to 20 cycles
// Notes: Servo pulse widths are not timed, one frame is far too long
`timescale 1ns/1ps
module tb_top
	import fac_pkg::*;
;
	logic clk_sys_in, sys_rst_in, track_dc_in, dc_dir_in, wheel_in;
	bus_req_t bus_in;
	pkt_t pkt_in;
	logic [31:0] rdata, bus_rdata_out;
	logic [1:0] pin_in, pin_out, pin_oe_n_out;
	logic [N_OUT-1:0] fn_out;
	logic [2:0] sound_out;
	logic fb_ch1_out, fb_ch2_out, fb_dyn_out;
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	int i;
	logic [13:0] own_t [6] = '{14'h3, 14'h3, 14'h7F, 14'h80, 14'h27FF, 14'h2800};
	logic [13:0] pa_t [6] = '{14'h3, 14'h5, 14'h7F, 14'h80, 14'h27FF, 14'h2800};
	logic lng_t [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
	logic ch2_t [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

	// ------------------------------------------------------------
	// Design and far side
	// ------------------------------------------------------------
	function_action_controller #(.TICK_CYCLES(20)) dut (
		.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .bus_in(bus_in),
		.bus_rdata_out(bus_rdata_out), .pkt_in(pkt_in),
		.track_dc_in(track_dc_in), .dc_dir_in(dc_dir_in),
		.wheel_in(wheel_in), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe_n_out(pin_oe_n_out), .fn_out(fn_out),
		.sound_out(sound_out), .fb_ch1_out(fb_ch1_out),
		.fb_ch2_out(fb_ch2_out), .fb_dyn_out(fb_dyn_out));
	track_source src (.clk_sys_in(clk_sys_in), .pkt_out(pkt_in));

	// Clock and hang guard; one speed window makes most of 24000 cycles
	initial begin
		clk_sys_in = 1'b0;
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 24000) begin
			errors++;
			$display("Error at %0t: run did not finish", $time);
			end_of_test();
		end
	end

	// ------------------------------------------------------------
	// Access and compare tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		bus_in <= '{1'b1, 1'b0, a, d};
		@(posedge clk_sys_in);
		bus_in <= '0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge clk_sys_in);
		bus_in <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clk_sys_in);
		bus_in <= '0;
		@(negedge clk_sys_in);
		d = bus_rdata_out;
	endtask : rd
	task automatic mode(input logic [31:0] e);
		rd(REG_STATUS, rdata);
		chk({29'h0, rdata[2:0]}, e);
	endtask : mode
	// Feedback pulses stand one cycle after the packet edge
	task automatic pkt(input logic d, l, input logic [13:0] a,
		input logic fw, input logic [28:0] f, input logic ft, e1, e2);
		src.send(d, l, a, fw, f, ft);
		@(negedge clk_sys_in);
		chk(32'(fb_ch1_out), 32'(e1));
		chk(32'(fb_ch2_out), 32'(e2));
	endtask : pkt
	task automatic out_is(input int n, input logic e);
		repeat (4) @(negedge clk_sys_in);
		chk(32'(fn_out[n]), 32'(e));
	endtask : out_is
	task automatic wheel_pass();
		@(posedge clk_sys_in);
		wheel_in <= 1'b1;
		repeat (150) @(posedge clk_sys_in);
		wheel_in <= 1'b0;
		repeat (150) @(posedge clk_sys_in);
	endtask : wheel_pass
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	// ------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------
	initial begin
		bus_in = '0;
		track_dc_in = 1'b1;
		dc_dir_in = 1'b1;
		wheel_in = 1'b0;
		pin_in = 2'h0;
		sys_rst_in = 1'b1;
		repeat (3) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		rd(REG_CTRL, rdata);
		chk(rdata, CTRL_RESET);
		rd(REG_ADDR, rdata);
		chk(rdata, {18'h0, ADDR_RESET});
		$display("Test reset values done");
		// Analogue: F0 output follows direction, another takes its fixed state
		wr(REG_MAP_BASE + 6'h02, 32'h0001_00A0);
		wr(REG_MAP_BASE + 6'h03, 32'h0);
		wr(REG_OUT_BASE + 6'h03, 32'h20);
		repeat (1200) @(posedge clk_sys_in);
		mode(32'h4);
		out_is(2, 1'b1);
		out_is(3, 1'b1);
		dc_dir_in <= 1'b0;
		repeat (10) @(posedge clk_sys_in);
		out_is(2, 1'b0);
		wr(REG_CTRL, 32'h0);
		repeat (4) @(posedge clk_sys_in);
		mode(32'h2);
		track_dc_in <= 1'b0;
		$display("Test analogue mode done");
		// Address ranges at their edges, then feedback in both formats
		for (i = 0; i < 6; i++) begin
			wr(REG_ADDR, {18'h0, own_t[i]});
			pkt(1'b1, lng_t[i], pa_t[i], 1'b1, 29'h0, 1'b0, 1'b1,
				ch2_t[i]);
		end
		wr(REG_ADDR, 32'hFF);
		pkt(1'b0, 1'b0, 14'hFF, 1'b1, 29'h0, 1'b0, 1'b0, 1'b0);
		// Alternate format: 14 steps, speed 5 scales to 45, format bit low
		rd(REG_STATUS, rdata);
		chk(32'(rdata[11:3]), 32'h0000_00B6);
		$display("Test feedback done");
		// Statistics count faults among all packets
		wr(REG_STATS, 32'h0);
		pkt(1'b1, 1'b0, 14'h5, 1'b1, 29'h0, 1'b0, 1'b1, 1'b0);
		pkt(1'b1, 1'b0, 14'h5, 1'b1, 29'h0, 1'b1, 1'b0, 1'b0);
		rd(REG_STATS, rdata);
		chk(rdata, 32'h0001_0002);
		$display("Test statistics done");
		// Mapping per direction, inversion, off switch
		wr(REG_ADDR, 32'h3);
		wr(REG_MAP_BASE + 6'h02, 32'h0001_0041);
		pkt(1'b1, 1'b0, 14'h3, 1'b1, 29'h2, 1'b0, 1'b1, 1'b1);
		// DCC 28 steps: speed 5 scales to 20, forward, format bit high
		rd(REG_STATUS, rdata);
		chk(32'(rdata[11:3]), 32'h0000_0053);
		out_is(2, 1'b1);
		pkt(1'b1, 1'b0, 14'h3, 1'b0, 29'h2, 1'b0, 1'b1, 1'b1);
		out_is(2, 1'b0);
		wr(REG_OUT_BASE + 6'h02, 32'h1);
		out_is(2, 1'b1);
		wr(REG_OUT_BASE + 6'h02, 32'h0);
		wr(REG_MAP_BASE + 6'h02, 32'h0001_8C41);
		pkt(1'b1, 1'b0, 14'h3, 1'b1, 29'hA, 1'b0, 1'b1, 1'b1);
		out_is(2, 1'b0);
		$display("Test mapping done");
		// Sound pulse on a mapped function
		wr(REG_MAP_BASE + 6'h07, 32'h0001_0084);
		pkt(1'b1, 1'b0, 14'h3, 1'b1, 29'h10, 1'b0, 1'b1, 1'b1);
		i = 0;
		while (sound_out[0] !== 1'b1 && i < 8) begin
			@(negedge clk_sys_in);
			i++;
		end
		chk(32'(sound_out[0]), 32'h1);
		// Servo pin drives, the other stays an input
		wr(REG_CTRL, 32'h4);
		repeat (3) @(posedge clk_sys_in);
		chk(32'(pin_oe_n_out), 32'h2);
		// Early in a frame the servo pulse stands; the input pin stays low
		chk(32'(pin_out), 32'h1);
		$display("Test sound and servo done");
		// Wheel pulses toggle rear light and count revolutions
		wr(REG_MAP_BASE + 6'h01, 32'h0);
		wr(REG_CTRL, 32'h12);
		wheel_pass();
		chk(32'(fn_out[1]), 32'h1);
		wheel_pass();
		chk(32'(fn_out[1]), 32'h0);
		rd(REG_DIST, rdata);
		chk(rdata, 32'h1);
		$display("Test wheel sensor done");
		// Contact on pin 0 drives the high-current output; not as servo
		wr(REG_MAP_BASE + 6'h04, 32'h0002_0000);
		pin_in <= 2'h1;
		repeat (60) @(posedge clk_sys_in);
		out_is(4, 1'b1);
		wr(REG_CTRL, 32'h16);
		out_is(4, 1'b0);
		// Kick: full drive for one 50 ms unit, then off with F5 still on
		wr(REG_KICK, 32'h1);
		wr(REG_OUT_BASE + 6'h03, 32'h4);
		wr(REG_MAP_BASE + 6'h03, 32'h0001_00A5);
		pkt(1'b1, 1'b0, 14'h3, 1'b1, 29'h20, 1'b0, 1'b1, 1'b1);
		out_is(3, 1'b1);
		repeat (1100) @(posedge clk_sys_in);
		out_is(3, 1'b0);
		$display("Test pins and kick done");
		// Speed window closes after 1000 ticks of 20 cycles each
		chk(32'(fb_dyn_out), 32'h0);
		while (cyc < 20 * int'(SPEED_WIN_MS) + 100)
			@(negedge clk_sys_in);
		chk(32'(fb_dyn_out), 32'h1);
		rd(REG_SPEED, rdata);
		chk(rdata, 32'h1);
		pkt(1'b1, 1'b0, 14'h3, 1'b1, 29'h20, 1'b0, 1'b1, 1'b1);
		chk(32'(fb_dyn_out), 32'h0);
		$display("Test speed window done");
		end_of_test();
	end
endmodule : tb_top
